//--- irp_defines.svh
`ifndef IRP_DEFINES_SVH
`define IRP_DEFINES_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define IRP_N        8      // Interrupt latch bits, 0 is highest priority
`define IRP_IDX_W    3
`define IRP_PC_W     24
`define IRP_EXT_W    3      // External interrupt pins
`define IRP_CNT_W    3      // Hold-off counter width
`define IRP_SQ_W     4      // Stages squashed on a take

// ****************************************************************
// Latch bit positions
// ****************************************************************
`define IRP_BIT_EXT0  0     // External pins use bits 0..2
`define IRP_BIT_ARITH 3     // Arithmetic exception
`define IRP_BIT_INSTR 4     // Raised by an executing instruction
`define IRP_BIT_INT0  5     // Internal sources use bits 5..7
`define IRP_INT_W     3

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define IRP_LATCH_RST  8'h00
`define IRP_PC_RST     24'h000000
`define IRP_SQ_ALL     4'hf
`define IRP_SQ_NONE    4'h0
`define IRP_EXT_IDLE   3'h7      // Pins are active low
`define IRP_CNT_ZERO   3'h0
`define IRP_CNT_ONE    3'h1
`define IRP_VEC_SHIFT  2         // Vectors spaced four instructions apart
`define IRP_VEC_BASE   24'h000000

// ****************************************************************
// Hold-off lengths, cycles including the trigger cycle
// ****************************************************************
`define IRP_HOLD_BR     3
`define IRP_HOLD_ALOOP  4
`define IRP_HOLD_CLOOP  4
`define IRP_HOLD_LSTART 2
`define IRP_HOLD_ISR    4
`define IRP_HOLD_NEST   5

`endif

//--- irp_pkg.sv
`include "irp_defines.svh"

package irp_pkg;

    // ****************************************************************
    // State of the hold-off timer
    // ****************************************************************
    typedef struct packed {
        logic [`IRP_CNT_W-1:0] cnt;
    } irp_hold_s;

    // ****************************************************************
    // State of the pin synchroniser
    // ****************************************************************
    typedef struct packed {
        logic [`IRP_EXT_W-1:0] s1;
        logic [`IRP_EXT_W-1:0] s2;
        logic [`IRP_EXT_W-1:0] s3;
        logic [`IRP_EXT_W-1:0] lvl;
    } irp_sync_s;

    // ****************************************************************
    // State of the response controller
    // ****************************************************************
    typedef struct packed {
        logic [`IRP_N-1:0]    latch;
        logic [`IRP_N-1:0]    act;
        logic                 sticky;
        logic                 tgt_vld;
        logic [`IRP_PC_W-1:0] tgt;
        logic                 push;
        logic                 vfetch;
        logic [`IRP_SQ_W-1:0] squash;
        logic [`IRP_PC_W-1:0] ret;
        logic [`IRP_PC_W-1:0] vec;
        logic                 held;
    } irp_state_s;

endpackage

//--- irp_hold_timer.sv
`include "irp_defines.svh"

module irp_hold_timer
    import irp_pkg::*;
#(
    parameter int LEN = 2
) (
    input  wire logic i_mclk,   // Core clock
    input  wire logic i_arst_n, // Async reset, active low
    input  wire logic i_ce,     // Clock enable
    input  wire logic i_trig,   // Start of the hold-off window
    output logic      o_busy    // Window active, trigger cycle included
);

    irp_hold_s st_ff;
    irp_hold_s nxt_st;

    // Reload on trigger, else count down to zero
    always_comb begin
        nxt_st = st_ff;
        if (i_trig) begin
            nxt_st.cnt = `IRP_CNT_W'(LEN - 1);
        end else if (st_ff.cnt != `IRP_CNT_ZERO) begin
            nxt_st.cnt = st_ff.cnt - `IRP_CNT_ONE;
        end
    end

    // State register
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_ff.cnt <= `IRP_CNT_ZERO;
        end else if (i_ce) begin
            st_ff <= nxt_st;
        end
    end

    assign o_busy = i_trig || (st_ff.cnt != `IRP_CNT_ZERO);

endmodule

//--- irp_pin_sync.sv
`include "irp_defines.svh"

module irp_pin_sync
    import irp_pkg::*;
(
    input  wire logic                  i_mclk,   // Core clock
    input  wire logic                  i_arst_n, // Async reset, active low
    input  wire logic                  i_ce,     // Clock enable
    input  wire logic [`IRP_EXT_W-1:0] i_pin,    // Raw asynchronous pins
    output logic      [`IRP_EXT_W-1:0] o_level   // Filtered level
);

    irp_sync_s st_ff;
    irp_sync_s nxt_st;

    // Shift chain, level follows once stages two and three agree
    always_comb begin
        nxt_st     = st_ff;
        nxt_st.s1  = i_pin;
        nxt_st.s2  = st_ff.s1;
        nxt_st.s3  = st_ff.s2;
        nxt_st.lvl = o_level;
    end

    // State register
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_ff <= {4{`IRP_EXT_IDLE}};
        end else if (i_ce) begin
            st_ff <= nxt_st;
        end
    end

    // Agreement filter per pin
    always_comb begin
        for (int i = 0; i < `IRP_EXT_W; i++) begin
            o_level[i] = (st_ff.s2[i] == st_ff.s3[i]) ? st_ff.s3[i] : st_ff.lvl[i];
        end
    end

endmodule

//--- irp_resp_ctrl.sv
// Contract
// - Latch and recognise next cycle, not processed
// - Third cycle: push decode PC, vector, squash four
// - Delayed branch: push target, vector fetch later
// - PM conflict: stall one, then process
// - Instruction interrupt taken in execute, latch next
// - One instruction completes, four aborted
// - Arithmetic exception processed two cycles after
// - External pin interrupts see five cycle latency
// - Latch write: two more instructions first
// - Nesting adds one cycle before next take
// - Hold-off still latches, defers processing
// - Jump or call holds off three cycles
// - Branch in address with loop end holds
// - First cycle of uncached PM conflict holds
// - Arithmetic loop abort holds four cycles
// - Short counter loop expiry holds four cycles
// - Loop start of 1,2,4 holds two cycles
// - First four cycles of service routine hold
// - DMA or wait-state stall cycles hold
// - Respond if unmasked, enabled, highest priority
// - Sync, latch and recognise, then branch
// - Active routine's latch bit cleared every cycle
`include "irp_defines.svh"

module irp_resp_ctrl
    import irp_pkg::*;
(
    input  wire logic                  i_mclk,         // Core clock, 20 MHz
    input  wire logic                  i_arst_n,       // Async reset, active low
    input  wire logic                  i_ce,           // Clock enable, freezes state
    input  wire logic [`IRP_EXT_W-1:0] i_ext_irq_n,    // External interrupt pins, low active
    input  wire logic [`IRP_INT_W-1:0] i_int_req,      // Internal source pulses
    input  wire logic                  i_arith_exc,    // Arithmetic exception in execute
    input  wire logic                  i_sticky_clr,   // Software clears sticky status
    input  wire logic                  i_instr_irq,    // Executing instruction raises irq
    input  wire logic                  i_latch_wr,     // Latch register write
    input  wire logic [`IRP_N-1:0]     i_latch_wdata,  // Latch register write data
    input  wire logic [`IRP_N-1:0]     i_mask,         // Per-bit unmask
    input  wire logic                  i_glob_en,      // Global interrupt enable
    input  wire logic                  i_nest_en,      // Nesting enable bit
    input  wire logic                  i_rti,          // Return from interrupt executes
    input  wire logic [`IRP_PC_W-1:0]  i_decode_pc,    // Address of decode-stage instr
    input  wire logic                  i_branch_exec,  // Jump or call executes
    input  wire logic                  i_branch_dly,   // That branch is delayed
    input  wire logic [`IRP_PC_W-1:0]  i_branch_tgt,   // Target of that branch
    input  wire logic                  i_br_loop_end,  // Branch in address, loop end in fetch1
    input  wire logic                  i_pm_conflict,  // First cycle of uncached PM conflict
    input  wire logic                  i_aloop_abort,  // Arithmetic loop aborts
    input  wire logic                  i_cloop_expire, // Short counter loop expires
    input  wire logic                  i_loop_start,   // Loop start of 1, 2 or 4 instrs
    input  wire logic                  i_mem_stall,    // DMA conflict or wait state
    output logic                       o_push,         // Push return address, pulse
    output logic [`IRP_PC_W-1:0]       o_ret_addr,     // Return address to push
    output logic                       o_vec_fetch,    // Start vector fetch, pulse
    output logic [`IRP_PC_W-1:0]       o_vec_addr,     // Vector address
    output logic [`IRP_SQ_W-1:0]       o_squash,       // Turn stages into nop, pulse
    output logic [`IRP_N-1:0]          o_latch,        // Interrupt latch register
    output logic [`IRP_N-1:0]          o_active,       // Routines in service
    output logic                       o_sticky,       // Arithmetic sticky status
    output logic                       o_held          // Processing held off
);

    // ****************************************************************
    // Hold-off sources
    // ****************************************************************

    logic [`IRP_EXT_W-1:0] ext_lvl_n;
    logic                  br_busy;
    logic                  aloop_busy;
    logic                  cloop_busy;
    logic                  lstart_busy;
    logic                  isr_busy;
    logic                  nest_busy;
    logic                  hold;

    irp_state_s st_ff;
    irp_state_s nxt_st;

    // Pin synchroniser feeding the latch
    irp_pin_sync u_pin_sync (
        .i_mclk   (i_mclk),
        .i_arst_n (i_arst_n),
        .i_ce     (i_ce),
        .i_pin    (i_ext_irq_n),
        .o_level  (ext_lvl_n)
    );

    // Jump or call plus two cycles
    irp_hold_timer #(.LEN(`IRP_HOLD_BR)) u_hold_br (
        .i_mclk   (i_mclk),
        .i_arst_n (i_arst_n),
        .i_ce     (i_ce),
        .i_trig   (i_branch_exec),
        .o_busy   (br_busy)
    );

    // Arithmetic loop abort plus three
    irp_hold_timer #(.LEN(`IRP_HOLD_ALOOP)) u_hold_aloop (
        .i_mclk   (i_mclk),
        .i_arst_n (i_arst_n),
        .i_ce     (i_ce),
        .i_trig   (i_aloop_abort),
        .o_busy   (aloop_busy)
    );

    // Short counter loop expiry plus three
    irp_hold_timer #(.LEN(`IRP_HOLD_CLOOP)) u_hold_cloop (
        .i_mclk   (i_mclk),
        .i_arst_n (i_arst_n),
        .i_ce     (i_ce),
        .i_trig   (i_cloop_expire),
        .o_busy   (cloop_busy)
    );

    // Loop start plus one
    irp_hold_timer #(.LEN(`IRP_HOLD_LSTART)) u_hold_lstart (
        .i_mclk   (i_mclk),
        .i_arst_n (i_arst_n),
        .i_ce     (i_ce),
        .i_trig   (i_loop_start),
        .o_busy   (lstart_busy)
    );

    // First four cycles of a service routine
    irp_hold_timer #(.LEN(`IRP_HOLD_ISR)) u_hold_isr (
        .i_mclk   (i_mclk),
        .i_arst_n (i_arst_n),
        .i_ce     (i_ce),
        .i_trig   (st_ff.vfetch),
        .o_busy   (isr_busy)
    );

    // One cycle more when nesting
    irp_hold_timer #(.LEN(`IRP_HOLD_NEST)) u_hold_nest (
        .i_mclk   (i_mclk),
        .i_arst_n (i_arst_n),
        .i_ce     (i_ce),
        .i_trig   (st_ff.vfetch),
        .o_busy   (nest_busy)
    );

    // Union of every hold-off condition
    assign hold = br_busy || aloop_busy || cloop_busy || lstart_busy
               || i_br_loop_end
               || i_pm_conflict
               || i_mem_stall
               || (i_nest_en ? nest_busy : isr_busy);

    // ****************************************************************
    // Recognition and response
    // ****************************************************************

    logic [`IRP_N-1:0]     allow;
    logic [`IRP_N-1:0]     cand;
    logic                  take;
    logic [`IRP_IDX_W-1:0] take_idx;
    logic                  instr_take;
    logic                  blk;
    logic                  rti_blk;

    // Priority gate and encoder
    always_comb begin
        blk   = 1'b0;
        allow = '0;
        for (int i = 0; i < `IRP_N; i++) begin
            if (st_ff.act[i]) begin
                blk = 1'b1;
            end
            allow[i] = !blk && (i_nest_en || (st_ff.act == '0));
        end
        cand = (st_ff.latch & i_mask & allow & ~st_ff.act)
             & {`IRP_N{i_glob_en}};
        cand[`IRP_BIT_INSTR] = cand[`IRP_BIT_INSTR]
                            || (i_instr_irq && i_mask[`IRP_BIT_INSTR]
                                && allow[`IRP_BIT_INSTR] && i_glob_en);
        take     = !hold && (cand != '0);
        take_idx = '0;
        for (int i = `IRP_N - 1; i >= 0; i--) begin
            if (cand[i]) begin
                take_idx = `IRP_IDX_W'(i);
            end
        end
        instr_take = take && (take_idx == `IRP_IDX_W'(`IRP_BIT_INSTR)) && i_instr_irq;
    end

    // Next state
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.push   = 1'b0;
        nxt_st.vfetch = 1'b0;
        nxt_st.squash = `IRP_SQ_NONE;
        nxt_st.held   = hold;
        rti_blk       = 1'b0;

        // Sticky status one cycle after the exception, set wins
        if (i_arith_exc) begin
            nxt_st.sticky = 1'b1;
        end else if (i_sticky_clr) begin
            nxt_st.sticky = 1'b0;
        end

        // Latch: software write, then sources OR in
        if (i_latch_wr) begin
            nxt_st.latch = i_latch_wdata;
        end
        for (int i = 0; i < `IRP_EXT_W; i++) begin
            nxt_st.latch[`IRP_BIT_EXT0 + i] = nxt_st.latch[`IRP_BIT_EXT0 + i]
                                            || !ext_lvl_n[i];
        end
        for (int i = 0; i < `IRP_INT_W; i++) begin
            nxt_st.latch[`IRP_BIT_INT0 + i] = nxt_st.latch[`IRP_BIT_INT0 + i]
                                            || i_int_req[i];
        end
        nxt_st.latch[`IRP_BIT_ARITH] = nxt_st.latch[`IRP_BIT_ARITH] || st_ff.sticky;
        nxt_st.latch[`IRP_BIT_INSTR] = nxt_st.latch[`IRP_BIT_INSTR] || instr_take;
        nxt_st.latch = nxt_st.latch & ~st_ff.act;

        // Delayed branch target kept until the branch hold-off ends
        if (i_branch_exec && i_branch_dly) begin
            nxt_st.tgt_vld = 1'b1;
            nxt_st.tgt     = i_branch_tgt;
        end else if (take || !br_busy) begin
            nxt_st.tgt_vld = 1'b0;
        end

        // Return from the highest priority routine
        if (i_rti) begin
            for (int i = 0; i < `IRP_N; i++) begin
                if (st_ff.act[i] && !rti_blk) begin
                    nxt_st.act[i] = 1'b0;
                    rti_blk       = 1'b1;
                end
            end
        end

        // Take: push, vector fetch, squash the four younger
        if (take) begin
            nxt_st.push   = 1'b1;
            nxt_st.vfetch = 1'b1;
            nxt_st.squash = `IRP_SQ_ALL;
            nxt_st.ret    = st_ff.tgt_vld ? st_ff.tgt : i_decode_pc;
            nxt_st.vec    = `IRP_VEC_BASE
                          | (`IRP_PC_W'(take_idx) << `IRP_VEC_SHIFT);
            nxt_st.act[take_idx] = 1'b1;
        end
    end

    // State register
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_ff <= '{latch: `IRP_LATCH_RST, act: `IRP_LATCH_RST, sticky: 1'b0,
                       tgt_vld: 1'b0, tgt: `IRP_PC_RST, push: 1'b0, vfetch: 1'b0,
                       squash: `IRP_SQ_NONE, ret: `IRP_PC_RST, vec: `IRP_PC_RST,
                       held: 1'b0};
        end else if (i_ce) begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign o_push      = st_ff.push;
    assign o_ret_addr  = st_ff.ret;
    assign o_vec_fetch = st_ff.vfetch;
    assign o_vec_addr  = st_ff.vec;
    assign o_squash    = st_ff.squash;
    assign o_latch     = st_ff.latch;
    assign o_active    = st_ff.act;
    assign o_sticky    = st_ff.sticky;
    assign o_held      = st_ff.held;

    // ****************************************************************
    // Checks
    // ****************************************************************

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_arst_n || !i_ce);

    chk_take_response: assert property (take |=> o_push && o_vec_fetch
        && o_squash == `IRP_SQ_ALL) else $error("take without full response");
    chk_hold_defers: assert property (hold |=> !o_push)
        else $error("push during hold-off");
    chk_ret_decode: assert property (take && !st_ff.tgt_vld
        |=> o_ret_addr == $past(i_decode_pc)) else $error("wrong return address");
    chk_ret_target: assert property (take && st_ff.tgt_vld
        |=> o_ret_addr == $past(st_ff.tgt)) else $error("branch target not pushed");
    chk_branch_window: assert property (i_branch_exec |=> !o_push [*3])
        else $error("take inside branch window");
    chk_isr_window: assert property (o_push && !i_nest_en
        |=> !o_push [*4]) else $error("take inside routine entry");
    chk_nest_window: assert property (o_push && i_nest_en
        |=> !o_push [*5]) else $error("nesting extra cycle missing");
    chk_latch_clear: assert property (st_ff.act != '0
        |=> (o_latch & $past(st_ff.act)) == '0) else $error("active latch not cleared");
    chk_arith_path: assert property (i_arith_exc && !st_ff.act[`IRP_BIT_ARITH]
        |=> o_sticky ##1 o_latch[`IRP_BIT_ARITH]) else $error("arith latch late");
    chk_instr_latch: assert property (instr_take
        |=> o_latch[`IRP_BIT_INSTR] && o_vec_fetch) else $error("instr latch missing");

    cov_take:   cover property (take ##1 o_vec_fetch);
    cov_branch: cover property (take && st_ff.tgt_vld);
    cov_nest:   cover property (take && i_nest_en && st_ff.act != '0);
    cov_instr:  cover property (instr_take);

endmodule

//--- irp_pipe_model.sv
`include "irp_defines.svh"

module irp_pipe_model
    import irp_pkg::*;
(
    input  wire logic                 i_mclk,      // Core clock
    input  wire logic                 i_arst_n,    // Async reset, active low
    input  wire logic                 i_vec_fetch, // Redirect to the vector
    input  wire logic [`IRP_PC_W-1:0] i_vec_addr,  // Vector address
    input  wire logic [`IRP_SQ_W-1:0] i_squash,    // Stages turned into nop
    output logic      [`IRP_PC_W-1:0] o_decode_pc, // Address in decode
    output logic      [3:0]           o_nop_cnt    // Nops on the last take
);
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************************
    // Sequencer stand-in
    // ****************************************************************
    // Decode address walks on each cycle and jumps on a vector fetch
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_decode_pc <= 24'h000100;
            o_nop_cnt   <= 4'h0;
        end else if (i_vec_fetch) begin
            o_decode_pc <= i_vec_addr;
            o_nop_cnt   <= 4'($countones(i_squash));
        end else begin
            o_decode_pc <= o_decode_pc + 24'h000001;
        end
    end
endmodule

//--- tb_interrupt_pipeline_response.sv
`include "irp_defines.svh"

module tb_interrupt_pipeline_response
    import irp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************************
    // Signals
    // ****************************************************************
    logic i_mclk, i_arst_n, i_ce, i_arith_exc, i_sticky_clr, i_instr_irq, i_latch_wr;
    logic i_glob_en, i_nest_en, i_rti, i_branch_exec, i_branch_dly, i_br_loop_end;
    logic i_pm_conflict, i_aloop_abort, i_cloop_expire, i_loop_start, i_mem_stall;
    logic [`IRP_EXT_W-1:0] i_ext_irq_n;
    logic [`IRP_INT_W-1:0] i_int_req;
    logic [`IRP_N-1:0]     i_latch_wdata, i_mask, o_latch, o_active;
    logic [`IRP_PC_W-1:0]  i_branch_tgt, i_decode_pc, o_ret_addr, o_vec_addr, pc_take;
    logic [`IRP_SQ_W-1:0]  o_squash;
    logic                  o_push, o_vec_fetch, o_sticky, o_held;
    logic [3:0]            nop_cnt;
    logic                  held1;
    int                    fails, n_tests;

    irp_resp_ctrl u_dut (.i_mclk, .i_arst_n, .i_ce, .i_ext_irq_n, .i_int_req, .i_arith_exc,
        .i_sticky_clr, .i_instr_irq, .i_latch_wr, .i_latch_wdata, .i_mask, .i_glob_en,
        .i_nest_en, .i_rti, .i_decode_pc, .i_branch_exec, .i_branch_dly, .i_branch_tgt,
        .i_br_loop_end, .i_pm_conflict, .i_aloop_abort, .i_cloop_expire, .i_loop_start,
        .i_mem_stall, .o_push, .o_ret_addr, .o_vec_fetch, .o_vec_addr, .o_squash, .o_latch,
        .o_active, .o_sticky, .o_held);

    irp_pipe_model u_pipe (.i_mclk, .i_arst_n, .i_vec_fetch(o_vec_fetch),
        .i_vec_addr(o_vec_addr), .i_squash(o_squash), .o_decode_pc(i_decode_pc),
        .o_nop_cnt(nop_cnt));

    // Core clock, 50 ns period
    always #25 i_mclk = ~i_mclk;

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Reset with every source idle
    task automatic rst();
        i_arst_n <= 1'b0;
        {i_int_req, i_arith_exc, i_instr_irq, i_latch_wr, i_rti, i_nest_en} <= '0;
        {i_branch_exec, i_branch_dly, i_aloop_abort, i_cloop_expire, i_loop_start} <= '0;
        {i_mem_stall, i_pm_conflict, i_br_loop_end} <= '0;
        i_mask      <= 8'hff;
        i_glob_en   <= 1'b1;
        i_ext_irq_n <= `IRP_EXT_IDLE;
        repeat (2) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        @(posedge i_mclk);
    endtask

    // Counts edges from the stimulus edge to the push; levels drop at edge lvl
    task automatic to_push(input int exp, input int lvl);
        int n;
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
            {i_int_req, i_arith_exc, i_instr_irq, i_latch_wr, i_rti} <= '0;
            {i_branch_exec, i_branch_dly, i_aloop_abort, i_cloop_expire, i_loop_start} <= '0;
            if (n >= lvl)
                {i_mem_stall, i_pm_conflict, i_br_loop_end} <= '0;
            #1;
            if (n == 1)
                held1 = o_held;
            if (o_push !== 1'b1)
                pc_take = i_decode_pc;
        end while (o_push !== 1'b1 && n < 20);
        check("push delay", n, exp);
        if (o_push !== 1'b1)
            print_verdict();
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_soft();
        rst();
        @(posedge i_mclk) i_int_req <= 3'h1;
        to_push(2, 1);
        check("held", held1, 1'b0);
        check("ret", o_ret_addr, pc_take);
        check("vec", o_vec_addr, 24'h000014);
        check("squash", o_squash, `IRP_SQ_ALL);
        check("active", o_active, 8'h20);
        @(posedge i_mclk) #1;
        check("latch", o_latch, 8'h00);
        check("nops", nop_cnt, 4'h4);
        $display("soft source test done");
    endtask

    task automatic t_sources();
        rst();
        @(posedge i_mclk) i_arith_exc <= 1'b1;
        to_push(3, 1);
        check("sticky", o_sticky, 1'b1);
        check("vec", o_vec_addr, 24'h00000c);
        @(posedge i_mclk) i_sticky_clr <= 1'b1;
        @(posedge i_mclk) i_sticky_clr <= 1'b0;
        #1 check("sticky clr", o_sticky, 1'b0);
        rst();
        @(posedge i_mclk) {i_latch_wr, i_latch_wdata} <= {1'b1, 8'h40};
        to_push(2, 1);
        check("vec", o_vec_addr, 24'h000018);
        rst();
        @(posedge i_mclk) i_instr_irq <= 1'b1;
        to_push(1, 1);
        check("latch", o_latch[`IRP_BIT_INSTR], 1'b1);
        rst();
        @(posedge i_mclk) i_ext_irq_n <= 3'h6;
        to_push(5, 1);
        check("vec", o_vec_addr, 24'h000000);
        check("active", o_active, 8'h01);
        $display("source latency test done");
    endtask

    task automatic t_holds();
        int exp[8] = '{4, 5, 5, 3, 5, 3, 3, 4};
        int lvl[8] = '{1, 1, 1, 1, 4, 2, 2, 1};
        for (int k = 0; k < 8; k++) begin
            rst();
            @(posedge i_mclk);
            i_int_req <= (k == 7) ? 3'h0 : 3'h1;
            {i_branch_exec, i_aloop_abort, i_cloop_expire} <= 3'(8'h04 >> k);
            {i_loop_start, i_mem_stall, i_pm_conflict, i_br_loop_end} <= 4'(8'h40 >> k);
            if (k == 7) begin
                @(posedge i_mclk) {i_int_req, i_branch_exec, i_branch_dly} <= 5'h07;
                i_branch_tgt <= 24'h00abc0;
            end
            to_push(exp[k], lvl[k]);
            check("held", held1, 1'b1);
        end
        check("ret", o_ret_addr, 24'h00abc0);
        $display("hold-off test done");
    endtask

    task automatic t_mask();
        int pushes;
        pushes = 0;
        rst();
        @(posedge i_mclk) {i_mask, i_int_req} <= {8'h7f, 3'h5};
        to_push(2, 1);
        check("vec", o_vec_addr, 24'h000014);
        @(posedge i_mclk) i_rti <= 1'b1;
        @(posedge i_mclk) i_rti <= 1'b0;
        repeat (6) @(posedge i_mclk) #1 pushes += int'(o_push !== 1'b0);
        @(posedge i_mclk) {i_mask, i_glob_en} <= {8'hff, 1'b0};
        repeat (4) @(posedge i_mclk) #1 pushes += int'(o_push !== 1'b0);
        check("masked push", pushes, 0);
        check("latch", o_latch, 8'h80);
        check("active", o_active, 8'h00);
        @(posedge i_mclk) i_glob_en <= 1'b1;
        to_push(1, 1);
        check("vec", o_vec_addr, 24'h00001c);
        $display("mask test done");
    endtask

    task automatic t_nest();
        rst();
        @(posedge i_mclk) {i_nest_en, i_int_req} <= {1'b1, 3'h2};
        to_push(2, 1);
        @(posedge i_mclk) i_int_req <= 3'h1;
        to_push(5, 1);
        check("held", held1, 1'b1);
        check("vec", o_vec_addr, 24'h000014);
        check("active", o_active, 8'h60);
        @(posedge i_mclk) i_rti <= 1'b1;
        @(posedge i_mclk) i_rti <= 1'b0;
        #1 check("active", o_active, 8'h40);
        $display("nesting test done");
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {i_mclk, i_ce, i_sticky_clr, i_latch_wdata, i_branch_tgt} = {1'b0, 1'b1, 1'b0, 32'h0};
        fails = 0;
        n_tests = 0;
        pc_take = '0;
        rst();
        t_soft();
        t_sources();
        t_holds();
        t_mask();
        t_nest();
        print_verdict();
    end
endmodule
